// ===== include/lcdpc_pkg.sv
// constants and types of the lcd power control and reset block
// ==========================================================
// Summary of operation
// - icon outputs: two commons, ten segments, ground when off
// - supply enable clear switches booster and converter off
// - mode pin low: both on; high: converter only
// - booster runs only while selected master clock runs
// - four-bit contrast register selects sixteen levels
// - one bias bit picks quarter or fifth bias
// - reset pin low loads defaults into every register
// - reset clears expanded, icon blink, double height, style
// - reset sets increment, clears shift on write
// - reset selects two-line display
// - reset clears extra duty, reverse and all-on
// - reset clears halt, supply, soft reset; fifth bias; contrast ones
// - reset clears icon display enable and icon bits
// - reset leaves display memories untouched
// - power command carries bias, halt, supply, soft reset
// - busy only during clear or soft reset; commands refused
package lcdpc_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MCLK_IDLE_NS = 100000;
	localparam int MCLK_IDLE_CYC = MCLK_IDLE_NS / CLK_PERIOD_NS;
	localparam int CLEAR_BUSY_MCLK = 34;
	localparam int ICON_HALF_MCLK = 64;

	// ==========================================================
	// register byte offsets
	localparam logic [4:0] OFS_CMD = 5'h00;
	localparam logic [4:0] OFS_MODE = 5'h04;
	localparam logic [4:0] OFS_POWER = 5'h08;
	localparam logic [4:0] OFS_LEVEL = 5'h0c;
	localparam logic [4:0] OFS_ICON = 5'h10;

	// ==========================================================
	// mode word fields
	localparam int MB_EXPANDED = 0;
	localparam int MB_ICON_BLINK = 1;
	localparam int MB_DOUBLE_HEIGHT = 2;
	localparam int MB_BLINK_STYLE = 3;
	localparam int MB_INCREMENT = 4;
	localparam int MB_SHIFT_WR = 5;
	localparam int MB_LINE_COUNT = 6;
	localparam int MB_DISPLAY_ON = 7;
	localparam int MB_CURSOR = 8;
	localparam int MB_CURSOR_BLINK = 9;
	localparam int MB_EXTRA_DUTY = 10;
	localparam int MB_REVERSE = 11;
	localparam int MB_ALL_ON = 12;
	localparam logic [12:0] MODE_RST = 13'h0010;

	// ==========================================================
	// power word fields
	localparam int PB_SOFT_RESET = 0;
	localparam int PB_SUPPLY_EN = 1;
	localparam int PB_HALT = 2;
	localparam int PB_BIAS = 3;
	localparam int PB_MODE_PIN = 4;
	localparam int PB_CLK_RUN = 5;
	localparam int PB_CONVERTER = 6;
	localparam int PB_BOOSTER = 7;
	localparam logic [3:0] POWER_RST = 4'h8;

	// ==========================================================
	// contrast, icons, busy
	localparam logic [3:0] LEVEL_RST = 4'hf;
	localparam int IB_DISPLAY = 10;
	localparam logic [10:0] ICON_RST = 11'h000;
	localparam int BUSY_BIT = 7;

	// ==========================================================
	// command decode: position of the leading one
	localparam int LK_CLEAR = 0;
	localparam int LK_ENTRY = 2;
	localparam int LK_CTRL = 3;
	localparam int LK_POWER = 4;
	localparam int LK_FUNC = 5;
	localparam int LK_VOLUME = 6;
	localparam logic [1:0] ICON_PREFIX = 2'h3;

	typedef enum logic [1:0] {
		LCDPC_IDLE = 2'b00,
		LCDPC_BUSY = 2'b01,
		LCDPC_ENDING = 2'b11
	} lcdpc_busy_e;

endpackage

// ===== core/lcdpc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module lcdpc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// pins in, synchronised out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // lcdpc_sync
`default_nettype wire

// ===== core/lcdpc_top.sv
// lcd power control, reset state and icon drive
`timescale 1ns/1ns
`default_nettype none
module lcdpc_top #(
	parameter int IDLE_CYC = lcdpc_pkg::MCLK_IDLE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// device pins
	input wire logic reset_pin_n,
	input wire logic supply_mode_pin,
	input wire logic clock_source_select,
	input wire logic osc_clk_in,
	input wire logic external_clock_in,
	// power supply control
	output logic booster_enable,
	output logic converter_enable,
	output logic booster_clk,
	output logic [3:0] contrast_level,
	output logic bias_fifth,
	output logic halt_active,
	// icon drive
	output logic [1:0] icon_common_out,
	output logic [9:0] icon_segment_outs,
	// display settings and busy
	output logic [12:0] display_config,
	output logic busy_flag
);
	import lcdpc_pkg::*;

	// ==========================================================
	// pin synchronisers
	logic [4:0] pin_s;
	logic rst_pin_s;
	logic mode_s;
	logic cksel_s;
	logic osc_s;
	logic ext_s;
	logic init;

	lcdpc_sync #(
		.W(5)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.din({external_clock_in, osc_clk_in, clock_source_select, supply_mode_pin, reset_pin_n}),
		.dout(pin_s)
	);

	assign rst_pin_s = pin_s[0];
	assign mode_s = pin_s[1];
	assign cksel_s = pin_s[2];
	assign osc_s = pin_s[3];
	assign ext_s = pin_s[4];

	// pin low holds every register at default
	assign init = srst | ~rst_pin_s;

	// ==========================================================
	// master clock selection and activity
	logic mclk_s;
	logic mclk_d;
	logic mrise;
	logic clk_running;
	logic [16:0] idle_cnt;

	assign mclk_s = cksel_s ? ext_s : osc_s;

	always_ff @(posedge clk) begin
		if (srst) begin
			mclk_d <= 1'b0;
		end else begin
			mclk_d <= mclk_s;
		end
	end

	assign mrise = mclk_s & ~mclk_d;

	always_ff @(posedge clk) begin
		if (srst) begin
			idle_cnt <= 17'(IDLE_CYC);
		end else if (mrise) begin
			idle_cnt <= 17'h00000;
		end else if (idle_cnt != 17'(IDLE_CYC)) begin
			idle_cnt <= idle_cnt + 17'h00001;
		end
	end

	assign clk_running = idle_cnt != 17'(IDLE_CYC);

	// ==========================================================
	// bus slave
	logic ack;
	logic wr_take;
	logic cmd_take;
	logic [7:0] cmd;
	logic [31:0] rd_mux;
	lcdpc_busy_e busy_st;

	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	always_ff @(posedge clk) begin
		if (srst) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
		end
	end

	assign wr_take = avs_write & ack;
	assign cmd = avs_writedata[7:0];
	// commands are dropped while busy
	assign cmd_take = wr_take & (avs_address == OFS_CMD) & avs_byteenable[0] & (busy_st == LCDPC_IDLE);

	// ==========================================================
	// command decode
	function automatic logic lead(input logic [7:0] d, input int k);
		return (d >> k) == 8'h01;
	endfunction

	logic [12:0] mode;
	logic [3:0] power;
	logic [3:0] level;
	logic [10:0] icon;
	logic exp;
	logic take_clear;
	logic take_entry;
	logic take_ctrl;
	logic take_power;
	logic take_func;
	logic take_volume;
	logic take_icon;
	logic acl_done;

	assign exp = mode[MB_EXPANDED];
	assign take_clear = cmd_take & lead(cmd, LK_CLEAR);
	assign take_entry = cmd_take & lead(cmd, LK_ENTRY);
	assign take_ctrl = cmd_take & lead(cmd, LK_CTRL);
	assign take_power = cmd_take & lead(cmd, LK_POWER);
	assign take_func = cmd_take & lead(cmd, LK_FUNC);
	assign take_volume = cmd_take & lead(cmd, LK_VOLUME);
	assign take_icon = cmd_take & (cmd[7:6] == ICON_PREFIX);

	// ==========================================================
	// mode registers
	always_ff @(posedge clk) begin
		if (init | acl_done) begin
			mode <= MODE_RST;
		end else if (take_func) begin
			mode[MB_ICON_BLINK] <= cmd[4];
			mode[MB_DOUBLE_HEIGHT] <= cmd[3];
			mode[MB_EXPANDED] <= cmd[2];
			mode[MB_BLINK_STYLE] <= cmd[1];
		end else if (take_entry & ~exp) begin
			mode[MB_INCREMENT] <= cmd[1];
			mode[MB_SHIFT_WR] <= cmd[0];
		end else if (take_entry & exp) begin
			mode[MB_LINE_COUNT] <= cmd[0];
		end else if (take_ctrl & ~exp) begin
			mode[MB_DISPLAY_ON] <= cmd[2];
			mode[MB_CURSOR] <= cmd[1];
			mode[MB_CURSOR_BLINK] <= cmd[0];
		end else if (take_ctrl & exp) begin
			mode[MB_EXTRA_DUTY] <= cmd[2];
			mode[MB_REVERSE] <= cmd[1];
			mode[MB_ALL_ON] <= cmd[0];
		end else if (take_clear) begin
			mode[MB_INCREMENT] <= 1'b1;
		end
	end

	// ==========================================================
	// power, contrast and icon registers
	always_ff @(posedge clk) begin
		if (init | acl_done) begin
			power <= POWER_RST;
		end else if (take_power & exp) begin
			power <= cmd[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (init | acl_done) begin
			level <= LEVEL_RST;
		end else if (take_volume & exp) begin
			level <= cmd[3:0];
		end
	end

	// display memories sit outside and see no reset here
	always_ff @(posedge clk) begin
		if (init | acl_done) begin
			icon <= ICON_RST;
		end else if (take_icon & ~exp) begin
			icon[5:0] <= cmd[5:0];
		end else if (take_icon & exp) begin
			icon[IB_DISPLAY] <= cmd[5];
			icon[9:6] <= cmd[3:0];
		end
	end

	// ==========================================================
	// busy sequencer for clear and soft reset
	logic [5:0] busy_cnt;

	assign acl_done = (busy_st == LCDPC_ENDING) & power[PB_SOFT_RESET];

	always_ff @(posedge clk) begin
		if (init) begin
			busy_st <= LCDPC_IDLE;
			busy_cnt <= 6'h00;
		end else begin
			unique case (busy_st)
				LCDPC_IDLE: begin
					if (take_clear | (take_power & exp & cmd[PB_SOFT_RESET])) begin
						busy_st <= LCDPC_BUSY;
						busy_cnt <= 6'h00;
					end
				end
				LCDPC_BUSY: begin
					if (mrise) begin
						if (busy_cnt == 6'(CLEAR_BUSY_MCLK - 1)) begin
							busy_st <= LCDPC_ENDING;
						end else begin
							busy_cnt <= busy_cnt + 6'h01;
						end
					end
				end
				LCDPC_ENDING: begin
					busy_st <= LCDPC_IDLE;
				end
				default: begin
					busy_st <= LCDPC_IDLE;
				end
			endcase
		end
	end

	assign busy_flag = busy_st != LCDPC_IDLE;

	// ==========================================================
	// supply enables and booster clock
	always_ff @(posedge clk) begin
		if (init) begin
			booster_enable <= 1'b0;
			converter_enable <= 1'b0;
			booster_clk <= 1'b0;
		end else begin
			converter_enable <= power[PB_SUPPLY_EN];
			booster_enable <= power[PB_SUPPLY_EN] & ~mode_s & clk_running;
			booster_clk <= power[PB_SUPPLY_EN] & ~mode_s & clk_running & mclk_s;
		end
	end

	assign contrast_level = level;
	assign bias_fifth = power[PB_BIAS];
	assign halt_active = power[PB_HALT];
	assign display_config = mode;

	// ==========================================================
	// static icon drive
	logic com;
	logic [6:0] icon_div;

	always_ff @(posedge clk) begin
		if (init) begin
			com <= 1'b0;
			icon_div <= 7'h00;
		end else if (mrise) begin
			if (icon_div == 7'(ICON_HALF_MCLK - 1)) begin
				icon_div <= 7'h00;
				com <= ~com;
			end else begin
				icon_div <= icon_div + 7'h01;
			end
		end
	end

	// lit segment drives opposite the common
	always_ff @(posedge clk) begin
		if (init | ~icon[IB_DISPLAY]) begin
			icon_common_out <= 2'h0;
			icon_segment_outs <= 10'h000;
		end else begin
			icon_common_out <= {2{com}};
			icon_segment_outs <= icon[9:0] ^ {10{com}};
		end
	end

	// ==========================================================
	// read path
	always_comb begin
		rd_mux = 32'h00000000;
		case (avs_address)
			OFS_CMD: rd_mux[BUSY_BIT] = busy_flag;
			OFS_MODE: rd_mux[12:0] = mode;
			OFS_POWER: begin
				rd_mux[3:0] = power;
				rd_mux[PB_MODE_PIN] = mode_s;
				rd_mux[PB_CLK_RUN] = clk_running;
				rd_mux[PB_CONVERTER] = converter_enable;
				rd_mux[PB_BOOSTER] = booster_enable;
			end
			OFS_LEVEL: rd_mux[3:0] = level;
			OFS_ICON: rd_mux[10:0] = icon;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & ~ack) begin
			avs_readdata <= rd_mux;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (init);

	sequence s_req;
		(avs_read | avs_write) && avs_waitrequest;
	endsequence

	sequence s_done;
		(avs_read | avs_write) && !avs_waitrequest;
	endsequence

	sequence s_busy_write;
		busy_flag && wr_take && (avs_address == OFS_CMD) && !acl_done;
	endsequence

	a_bus_answer: assert property (s_req |=> s_done)
		else $error("bus answer not given in one cycle");

	a_supply_off: assert property (!power[PB_SUPPLY_EN] |=> !booster_enable && !converter_enable)
		else $error("supply enable clear but booster or converter on");

	a_mode_pin_high: assert property (power[PB_SUPPLY_EN] && mode_s |=> !booster_enable && converter_enable)
		else $error("mode pin high must give converter only");

	a_mode_pin_low: assert property (power[PB_SUPPLY_EN] && !mode_s && clk_running
		|=> booster_enable && converter_enable)
		else $error("mode pin low must give booster and converter");

	a_boost_clock: assert property (booster_enable |-> $past(clk_running))
		else $error("booster on without running master clock");

	a_icon_blank: assert property (!icon[IB_DISPLAY] |=> icon_common_out == 2'h0 && icon_segment_outs == 10'h000)
		else $error("icon outputs not at ground while icons off");

	a_reset_load: assert property (@(posedge clk) disable iff (srst)
		$past(init) |-> level == LEVEL_RST && power == POWER_RST && mode == MODE_RST && icon == ICON_RST)
		else $error("register not at default after reset");

	a_power_cmd: assert property (take_power && exp |=> power == $past(cmd[3:0]))
		else $error("power command not stored");

	a_busy_refuse: assert property (s_busy_write |=> $stable(mode) && $stable(level) && $stable(power))
		else $error("command taken while busy");

	a_volume_cmd: assert property (take_volume && exp |=> level == $past(cmd[3:0]))
		else $error("contrast command not stored");

endmodule // lcdpc_top
`default_nettype wire

// ===== verif/lcdpc_host_model.sv
// host model: avalon-mm master and device reset pin
`timescale 1ns/1ns
`default_nettype none
module lcdpc_host_model (
	// clock
	input wire logic clk,
	// avalon-mm master
	output logic [4:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// device reset pin
	output logic reset_pin_n
);
	// ==========================================================
	// idle bus, pin low from power on
	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hf;
		reset_pin_n = 1'b0;
	end

	// ==========================================================
	// one transfer, held until waitrequest low
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		avs_writedata <= ~d;
		@(posedge clk);
	endtask

	// command byte, written at the command offset
	task automatic cmd(input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, 5'h00, {24'h000000, d}, q);
	endtask

	// reset pin level, then settle
	task automatic pin(input logic lvl);
		reset_pin_n <= lvl;
		repeat (4) @(posedge clk);
	endtask

	// byte enables for the transfers that follow
	task automatic be(input logic [3:0] v);
		avs_byteenable <= v;
	endtask
endmodule // lcdpc_host_model
`default_nettype wire

// ===== verif/test_lcd_power_control_and_reset_state.sv
// testbench of the lcd power control and reset block
`timescale 1ns/1ns
`default_nettype none
module test_lcd_power_control_and_reset_state;
	import lcdpc_pkg::*;
	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic supply_mode_pin = 1'b0;
	logic clock_source_select = 1'b0;
	logic osc_clk_in = 1'b0;
	logic external_clock_in = 1'b0;
	logic osc_run = 1'b1;
	logic ext_run = 1'b0;
	logic [4:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, reset_pin_n;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable, contrast_level;
	logic booster_enable, converter_enable, booster_clk, bias_fifth, halt_active, busy_flag, seen;
	logic [1:0] icon_common_out;
	logic [9:0] icon_segment_outs;
	logic [12:0] display_config;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	// command, offset, expected read
	localparam logic [47:0] ROWS [17] = '{
		48'h02_04_00000010, 48'h02_08_00000028, 48'h02_0c_0000000f, 48'h02_10_00000000,
		48'h02_00_00000000, 48'h05_04_00000020, 48'h0f_04_000003a0, 48'h24_04_000003a1,
		48'h05_04_000003e1, 48'h0f_04_00001fe1, 48'h4a_0c_0000000a, 48'hf5_10_00000540,
		48'h1e_08_000000ee, 48'h20_04_00001fe0, 48'hc5_10_00000545, 48'h14_08_000000ee,
		48'h8a_04_00001fe0};

	// ==========================================================
	// clocks and models
	always #2 clk = ~clk;
	always begin
		repeat (4) @(posedge clk);
		osc_clk_in <= osc_run ? ~osc_clk_in : 1'b0;
		external_clock_in <= ext_run ? ~external_clock_in : 1'b0;
	end
	lcdpc_top #(.IDLE_CYC(64)) u_dut (.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.reset_pin_n(reset_pin_n), .supply_mode_pin(supply_mode_pin),
		.clock_source_select(clock_source_select), .osc_clk_in(osc_clk_in),
		.external_clock_in(external_clock_in), .booster_enable(booster_enable),
		.converter_enable(converter_enable), .booster_clk(booster_clk), .contrast_level(contrast_level),
		.bias_fifth(bias_fifth), .halt_active(halt_active), .icon_common_out(icon_common_out),
		.icon_segment_outs(icon_segment_outs), .display_config(display_config), .busy_flag(busy_flag));
	lcdpc_host_model u_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .reset_pin_n(reset_pin_n));

	// ==========================================================
	// checking
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		u_host.xfer(1'b0, OFS_CMD, 32'h0, q);
		check({31'h0, q[BUSY_BIT]}, 32'h1);
		while (q[BUSY_BIT] !== 1'b0 && n < 400) begin
			u_host.xfer(1'b0, OFS_CMD, 32'h0, q);
			n++;
		end
		check({31'h0, q[BUSY_BIT]}, 32'h0);
	endtask
	task automatic stop_test();
		if (bad_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	// ==========================================================
	// sequence
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		u_host.pin(1'b1);
		for (int i = 0; i < 17; i++) begin
			u_host.cmd(ROWS[i][47:40]);
			rd(ROWS[i][36:32], ROWS[i][31:0]);
		end
		u_host.xfer(1'b1, OFS_LEVEL, 32'h3, q);
		rd(OFS_LEVEL, 32'ha);
		rd(5'h14, 32'h0);
		check({28'h0, halt_active, bias_fifth, booster_enable, converter_enable}, 32'hf);
		check({28'h0, contrast_level}, 32'ha);
		check({20'h0, icon_common_out, icon_segment_outs ^ {10{icon_common_out[0]}}},
			{20'h0, {2{icon_common_out[0]}}, 10'h145});
		supply_mode_pin <= 1'b1;
		repeat (5) @(posedge clk);
		check({30'h0, booster_enable, converter_enable}, 32'h1);
		u_host.cmd(8'h24);
		u_host.cmd(8'h18);
		repeat (2) @(posedge clk);
		check({30'h0, booster_enable, converter_enable}, 32'h0);
		supply_mode_pin <= 1'b0;
		u_host.cmd(8'h1a);
		repeat (2) @(posedge clk);
		check({30'h0, booster_enable, converter_enable}, 32'h3);
		osc_run <= 1'b0;
		repeat (100) @(posedge clk);
		u_host.xfer(1'b0, OFS_POWER, 32'h0, q);
		check(q & 32'h3f, 32'h0a);
		check({31'h0, booster_clk}, 32'h0);
		clock_source_select <= 1'b1;
		ext_run <= 1'b1;
		repeat (40) @(posedge clk);
		seen = 1'b0;
		repeat (16) begin
			@(posedge clk);
			seen = seen | booster_clk;
		end
		check({31'h0, seen}, 32'h1);
		u_host.cmd(8'h20);
		u_host.cmd(8'h01);
		u_host.cmd(8'h08);
		wait_idle();
		rd(OFS_MODE, 32'h1ff0);
		u_host.cmd(8'h24);
		u_host.cmd(8'h11);
		wait_idle();
		rd(OFS_MODE, 32'h10);
		rd(OFS_POWER, 32'h28);
		rd(OFS_LEVEL, 32'hf);
		u_host.cmd(8'h24);
		u_host.cmd(8'h0c);
		u_host.pin(1'b0);
		u_host.cmd(8'h0c);
		check({19'h0, display_config}, 32'h10);
		check({26'h0, bias_fifth, halt_active, contrast_level}, 32'h2f);
		u_host.pin(1'b1);
		u_host.cmd(8'h0c);
		repeat (2) @(posedge clk);
		check({19'h0, display_config}, 32'h90);
		u_host.be(4'he);
		u_host.cmd(8'h0f);
		u_host.be(4'h1);
		u_host.xfer(1'b1, OFS_CMD, 32'hffffff0e, q);
		u_host.be(4'hf);
		rd(OFS_MODE, 32'h190);
		rd(5'h13, 32'h0);
		u_host.cmd(8'h24);
		u_host.cmd(8'h1a);
		u_host.cmd(8'h43);
		repeat (2) @(posedge clk);
		check({27'h0, booster_enable, contrast_level}, 32'h13);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		check({25'h0, booster_enable, converter_enable, halt_active, contrast_level}, 32'h0f);
		check({19'h0, display_config}, 32'h10);
		repeat (2) @(posedge clk);
		u_host.cmd(8'h0c);
		repeat (2) @(posedge clk);
		check({19'h0, display_config}, 32'h90);
		stop_test();
	end
endmodule // test_lcd_power_control_and_reset_state
`default_nettype wire
